// ===== common/omc_pkg.sv
package omc_pkg;
    // APB address width and register location (index times four)
    localparam int unsigned APB_AW = 12;
    localparam logic [11:0] OSC_MODE_IDX = 12'h0ca;
    localparam logic [11:0] OSC_MODE_ADDR = {OSC_MODE_IDX[9:0], 2'h0};
    // Field positions inside the mode register
    localparam int unsigned HOSC_STOP_BIT = 1;
    localparam int unsigned SLOW_SEL_BIT = 2;
    localparam int unsigned CPU_MODE_LSB = 3;
    localparam int unsigned CPU_MODE_MSB = 4;
    localparam logic [7:0] OSC_MODE_RESET = 8'h00;
    // Operating field encodings
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_IDLE = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    // High clock option codes on the strap pins
    localparam logic [2:0] OPT_FAST_RC = 3'h0;
    localparam logic [2:0] OPT_RC_XTAL = 3'h1;
    localparam logic [2:0] OPT_EXT_RC = 3'h2;
    localparam logic [2:0] OPT_XTAL_32K = 3'h3;
    localparam logic [2:0] OPT_XTAL_12M = 3'h4;
    localparam logic [2:0] OPT_XTAL_4M = 3'h5;
    // Oscillator cycle counts
    localparam int unsigned CNT_W = 12;
    localparam logic [11:0] CFG_LOSC_CYCLES = 12'h800;
    localparam logic [11:0] RESET_WARM_CYCLES = 12'h800;
    localparam logic [11:0] WAKE_XTAL_CYCLES = 12'h800;
    localparam logic [11:0] WAKE_RC_CYCLES = 12'h020;
    localparam logic [1:0] SLOW_DIV_LAST = 2'h3;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_CFG, ST_WARM, ST_RUN, ST_SLEEP, ST_IDLE, ST_WAKE
    } omc_state_t;
endpackage : omc_pkg

// ===== src/omc_cycle_counter.sv
`timescale 1ns/1ps
`default_nettype none
module omc_cycle_counter
    import omc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire logic tick_in,
    input wire logic [CNT_W-1:0] limit_in,
    output logic busy_out,
    output logic done_out
);
    logic [CNT_W-1:0] cnt_ff; // Ticks seen so far
    logic busy_ff;
    logic done_ff; // One-cycle pulse after the last tick

    // Start wins over a tick in the same cycle
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (start_in) begin
            cnt_ff <= '0;
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
        end else if (busy_ff && tick_in) begin
            if (cnt_ff == CNT_W'(limit_in - 1'b1)) begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
            end else begin
                cnt_ff <= CNT_W'(cnt_ff + 1'b1);
                done_ff <= 1'b0;
            end
        end else begin
            done_ff <= 1'b0;
        end
    end

    assign busy_out = busy_ff;
    assign done_out = done_ff;
endmodule : omc_cycle_counter
`default_nettype wire

// ===== src/omc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module omc_edge_sync (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic raw_in,
    output logic level_out,
    output logic rise_out
);
    logic meta_ff; // First stage, read only by stage_ff
    logic stage_ff;
    logic prev_ff;
    logic rise_ff;

    // Two-flop synchroniser, then a registered rising-edge detect
    // Stages reset high: a pin already high at release is not an edge,
    // so a running oscillator cannot shorten its first counted period
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_ff <= 1'b1;
            stage_ff <= 1'b1;
            prev_ff <= 1'b1;
            rise_ff <= 1'b0;
        end else begin
            meta_ff <= raw_in;
            stage_ff <= meta_ff;
            prev_ff <= stage_ff;
            rise_ff <= stage_ff & ~prev_ff;
        end
    end

    assign level_out = stage_ff;
    assign rise_out = rise_ff;
endmodule : omc_edge_sync
`default_nettype wire

// ===== src/omc_mode_ctrl.sv
// Overview of operation
// - Low RC clocks watchdog and slow mode
// - Slow instruction rate is low clock/4
// - Low RC stops in sleep, or in 32K idle with watchdog off
// - No separate low RC off control
// - Mode register layout, unused bits zero
// - Stop bit halts high osc, low runs
// - Select bit picks high or low clock
// - Mode field normal, sleep, idle codes
// - Stop bit halts option's high oscillators
// - Power-up waits 2048 low RC cycles
// - Reset warm-up 2048 high cycles
// - Wake warm-up 2048 crystal, 32 RC
// - Sleep bit clears on wake
// - Sleep wake resumes normal high-speed mode
// - Idle wake returns to previous mode
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl
    import omc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [APB_AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic hosc_clk_in,
    input wire logic losc_clk_in,
    input wire logic wake_in,
    input wire logic wdt_enable_in,
    input wire logic [2:0] high_clk_option_in,
    output logic int_high_rc_en_out,
    output logic rtc_xtal_en_out,
    output logic ext_osc_en_out,
    output logic int_low_rc_en_out,
    output logic sys_clk_sel_out,
    output logic cpu_tick_out,
    output logic wdt_tick_out,
    output logic cpu_run_out
);
    // Register fields
    logic high_osc_stop_ff;
    logic slow_clock_select_ff;
    logic [1:0] cpu_operating_field_ff;
    // Sequencer
    omc_state_t state_ff;
    omc_state_t nxt_state;
    logic start_pend_ff; // Counter start request for a new wait
    // Straps through two flops, then captured during configuration
    logic [3:0] strap_meta_ff;
    logic [3:0] strap_sync_ff;
    logic [2:0] option_ff;
    logic wdt_en_ff;
    // Clock selection
    logic sel_active_ff; // Source actually feeding the instruction tick
    logic [1:0] div_ff;
    // Oscillator edges and wake
    logic hosc_rise;
    logic losc_rise;
    logic wake_rise;
    // Counter
    logic cnt_tick;
    logic [CNT_W-1:0] cnt_limit;
    logic cnt_busy;
    logic cnt_done;
    // Bus
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic access;
    logic hit;
    logic wr_commit;
    logic [7:0] reg_view;
    // Output flops, then oscillator run terms and option decode
    logic int_high_rc_en_ff;
    logic rtc_xtal_en_ff;
    logic ext_osc_en_ff;
    logic losc_en_ff;
    logic cpu_tick_ff;
    logic wdt_tick_ff;
    logic cpu_run_ff;
    logic hosc_on;
    logic losc_on;
    logic is_32k;
    logic is_xtal;

    // Oscillator pins are foreign to sys_clk_in
    omc_edge_sync u_hosc_sync (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .raw_in(hosc_clk_in),
        .level_out(),
        .rise_out(hosc_rise)
    );
    omc_edge_sync u_losc_sync (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .raw_in(losc_clk_in),
        .level_out(),
        .rise_out(losc_rise)
    );
    omc_edge_sync u_wake_sync (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .raw_in(wake_in),
        .level_out(),
        .rise_out(wake_rise)
    );

    // One counter serves every wait; tick source follows the state
    assign cnt_tick = (state_ff == ST_CFG) ? losc_rise : hosc_rise;
    omc_cycle_counter u_wait_cnt (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .start_in(start_pend_ff),
        .tick_in(cnt_tick),
        .limit_in(cnt_limit),
        .busy_out(cnt_busy),
        .done_out(cnt_done)
    );

    // Option decode
    assign is_32k = (option_ff == OPT_XTAL_32K) || (option_ff == OPT_RC_XTAL);
    assign is_xtal = (option_ff == OPT_XTAL_32K) || (option_ff == OPT_XTAL_12M)
        || (option_ff == OPT_XTAL_4M);

    // Wait length per phase
    always_comb begin
        unique case (state_ff)
            ST_CFG: cnt_limit = CFG_LOSC_CYCLES;
            ST_WARM: cnt_limit = RESET_WARM_CYCLES;
            default: cnt_limit = is_xtal ? WAKE_XTAL_CYCLES : WAKE_RC_CYCLES;
        endcase
    end

    // Strap synchroniser; held once configuration ends
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            strap_meta_ff <= 4'h0;
            strap_sync_ff <= 4'h0;
            option_ff <= OPT_FAST_RC;
            wdt_en_ff <= 1'b0;
        end else begin
            strap_meta_ff <= {wdt_enable_in, high_clk_option_in};
            strap_sync_ff <= strap_meta_ff;
            if (state_ff == ST_CFG) begin
                option_ff <= strap_sync_ff[2:0];
                wdt_en_ff <= strap_sync_ff[3];
            end
        end
    end

    // Next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_CFG: if (cnt_done) nxt_state = ST_WARM;
            ST_WARM: if (cnt_done) nxt_state = ST_RUN;
            ST_RUN: begin
                if (cpu_operating_field_ff == MODE_SLEEP) begin
                    nxt_state = ST_SLEEP;
                end else if (cpu_operating_field_ff == MODE_IDLE) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SLEEP: if (wake_rise) nxt_state = ST_WAKE;
            ST_WAKE: if (cnt_done) nxt_state = ST_RUN;
            ST_IDLE: if (wake_rise) nxt_state = ST_RUN;
        endcase
    end

    // Sequencer flops; a wait begins on entry to a counted phase
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff <= ST_CFG;
            start_pend_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            start_pend_ff <= (nxt_state != state_ff)
                && (nxt_state == ST_WARM || nxt_state == ST_WAKE);
        end
    end

    // APB decode; the slave answers in the second access cycle
    assign access = psel_in && penable_in;
    assign hit = (paddr_in == OSC_MODE_ADDR);
    assign wr_commit = access && pready_ff && pwrite_in && hit && pstrb_in[0];
    assign reg_view = {3'h0, cpu_operating_field_ff, slow_clock_select_ff,
        high_osc_stop_ff, 1'h0};

    // Mode register; a software write outranks the wake-up clear
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            high_osc_stop_ff <= OSC_MODE_RESET[HOSC_STOP_BIT];
            slow_clock_select_ff <= OSC_MODE_RESET[SLOW_SEL_BIT];
            cpu_operating_field_ff <= OSC_MODE_RESET[CPU_MODE_MSB:CPU_MODE_LSB];
        end else if (wr_commit) begin
            high_osc_stop_ff <= pwdata_in[HOSC_STOP_BIT];
            slow_clock_select_ff <= pwdata_in[SLOW_SEL_BIT];
            // Reserved code is dropped, field keeps its value
            if (pwdata_in[CPU_MODE_MSB:CPU_MODE_LSB] != MODE_RSVD) begin
                cpu_operating_field_ff <= pwdata_in[CPU_MODE_MSB:CPU_MODE_LSB];
            end
        end else if (state_ff == ST_WAKE && cnt_done) begin
            cpu_operating_field_ff <= MODE_NORMAL;
            slow_clock_select_ff <= 1'b0;
            high_osc_stop_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && wake_rise) begin
            cpu_operating_field_ff <= MODE_NORMAL;
        end
    end

    // Bus answer flops; unmapped addresses get an error response
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= access && !pready_ff;
            pslverr_ff <= access && !pready_ff && !hit;
            if (access && !pready_ff && !pwrite_in && hit) begin
                prdata_ff <= {24'h00_0000, reg_view};
            end else begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    // High oscillator runs unless stopped by sleep, or by the stop bit in run or idle
    assign hosc_on = (state_ff != ST_SLEEP)
        && !(high_osc_stop_ff && (state_ff == ST_RUN || state_ff == ST_IDLE));
    // Only the sequencer state, option and watchdog gate the low RC
    assign losc_on = (state_ff != ST_SLEEP)
        && !(state_ff == ST_IDLE && is_32k && !wdt_en_ff);

    // Enables per option, registered to keep outputs glitch free
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int_high_rc_en_ff <= 1'b0;
            rtc_xtal_en_ff <= 1'b0;
            ext_osc_en_ff <= 1'b0;
            losc_en_ff <= 1'b1;
        end else begin
            int_high_rc_en_ff <= hosc_on
                && (option_ff == OPT_FAST_RC || option_ff == OPT_RC_XTAL);
            rtc_xtal_en_ff <= hosc_on && (option_ff == OPT_RC_XTAL);
            ext_osc_en_ff <= hosc_on && (option_ff == OPT_EXT_RC
                || option_ff == OPT_XTAL_32K || is_xtal);
            losc_en_ff <= losc_on;
        end
    end

    // Source changes only at the new source's edge, divider restarts,
    // so neither clock ever yields a shortened instruction period
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_active_ff <= 1'b0;
            div_ff <= 2'h0;
        end else if (slow_clock_select_ff != sel_active_ff
            && (slow_clock_select_ff ? losc_rise : hosc_rise)) begin
            sel_active_ff <= slow_clock_select_ff;
            div_ff <= 2'h0;
        end else if (sel_active_ff && losc_rise) begin
            div_ff <= 2'(div_ff + 1'b1);
        end
    end

    // Instruction tick, watchdog tick and run flag
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cpu_tick_ff <= 1'b0;
            wdt_tick_ff <= 1'b0;
            cpu_run_ff <= 1'b0;
        end else begin
            cpu_tick_ff <= (state_ff == ST_RUN) && (sel_active_ff
                ? (losc_rise && div_ff == SLOW_DIV_LAST) : hosc_rise);
            wdt_tick_ff <= losc_rise;
            cpu_run_ff <= (nxt_state == ST_RUN);
        end
    end

    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign int_high_rc_en_out = int_high_rc_en_ff;
    assign rtc_xtal_en_out = rtc_xtal_en_ff;
    assign ext_osc_en_out = ext_osc_en_ff;
    assign int_low_rc_en_out = losc_en_ff;
    assign sys_clk_sel_out = sel_active_ff;
    assign cpu_tick_out = cpu_tick_ff;
    assign wdt_tick_out = wdt_tick_ff;
    assign cpu_run_out = cpu_run_ff;

    // Helper: ticks seen while the wait counter is busy
    logic [CNT_W-1:0] hlp_ticks_ff;
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hlp_ticks_ff <= '0;
        end else if (start_pend_ff) begin
            hlp_ticks_ff <= '0;
        end else if (cnt_busy && cnt_tick) begin
            hlp_ticks_ff <= CNT_W'(hlp_ticks_ff + 1'b1);
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence wake_done_s;
        state_ff == ST_WAKE && cnt_done && !wr_commit;
    endsequence

    cfg_wait_a: assert property (
        state_ff == ST_CFG && cnt_done |-> hlp_ticks_ff == CFG_LOSC_CYCLES)
        else $error("configuration wait length wrong");
    reset_warm_a: assert property (
        state_ff == ST_WARM && cnt_done |-> hlp_ticks_ff == RESET_WARM_CYCLES
            ##1 state_ff == ST_RUN)
        else $error("reset warm-up length wrong");
    wake_warm_a: assert property (
        state_ff == ST_WAKE && cnt_done |-> hlp_ticks_ff ==
            (is_xtal ? WAKE_XTAL_CYCLES : WAKE_RC_CYCLES))
        else $error("wake warm-up length wrong");
    sleep_stop_a: assert property (
        state_ff == ST_SLEEP |=> !int_low_rc_en_out && !int_high_rc_en_out
            && !ext_osc_en_out)
        else $error("oscillator running in sleep");
    low_run_a: assert property (
        state_ff == ST_RUN |=> int_low_rc_en_out)
        else $error("low RC stopped outside sleep or idle");
    hosc_stop_a: assert property (
        state_ff == ST_RUN && high_osc_stop_ff |=> !int_high_rc_en_out
            && !rtc_xtal_en_out && !ext_osc_en_out && int_low_rc_en_out)
        else $error("stop bit did not halt high oscillator");
    slow_rate_a: assert property (
        state_ff == ST_RUN && sel_active_ff && losc_rise
            && div_ff != SLOW_DIV_LAST |=> !cpu_tick_out)
        else $error("slow tick not at every fourth edge");
    reg_zero_a: assert property (
        pready_out |-> prdata_out[31:5] == 27'h0 && prdata_out[0] == 1'b0)
        else $error("reserved bits read nonzero");
    mode_code_a: assert property (
        state_ff == ST_RUN && cpu_operating_field_ff == MODE_SLEEP
            |=> state_ff == ST_SLEEP)
        else $error("sleep code not honoured");
    wake_clear_a: assert property (
        wake_done_s |=> cpu_operating_field_ff == MODE_NORMAL
            && !slow_clock_select_ff && state_ff == ST_RUN)
        else $error("wake did not restore normal mode");
    idle_keep_a: assert property (
        state_ff == ST_IDLE && wake_rise && !wr_commit
            |=> $stable(slow_clock_select_ff) && state_ff == ST_RUN)
        else $error("idle wake changed the clock mode");
    clk_switch_a: assert property (
        $changed(sel_active_ff) |-> $past(sel_active_ff ? hosc_rise : losc_rise)
            && div_ff == 2'h0)
        else $error("clock switched off a source edge");
endmodule : omc_mode_ctrl
`default_nettype wire

// ===== testbench/test_oscillator_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_oscillator_mode_control
    import omc_pkg::*;
;
    // Oscillator periods in system cycles, slow enough for the samplers
    localparam int HP = 5;
    localparam int LP = 6;
    logic sys_clk_in = 1'b0; // System clock
    logic rstn_in = 1'b0; // Reset, active low
    logic psel = 1'b0; // APB request lines
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic hosc = 1'b0; // Oscillator models
    logic losc = 1'b0;
    logic wake = 1'b0; // Wake request level
    logic wdt_en = 1'b0; // Straps
    logic [2:0] hopt = 3'h0;
    logic [2:0] hph = 3'h0; // Oscillator phase counters
    logic [2:0] lph = 3'h0;
    logic [31:0] prdata; // Design outputs
    logic pready;
    logic pslverr;
    logic hrc_en;
    logic xtal_en;
    logic ext_en;
    logic lrc_en;
    logic clk_sel;
    logic cpu_tick;
    logic wdt_tick;
    logic cpu_run;
    logic [31:0] rd_v; // Last read result
    logic err_v;
    int cyc = 0; // Cycle count for latencies
    int bad_count = 0;
    int total_checks = 0;

    // Clock generator
    always #10 sys_clk_in = ~sys_clk_in;

    // Free running cycle count
    always @(posedge sys_clk_in) cyc <= cyc + 1;

    // Oscillators stand still while disabled, as real ones would
    always @(posedge sys_clk_in) begin
        if (hrc_en || ext_en) begin
            hph <= (hph == 3'h4) ? 3'h0 : hph + 3'h1;
            hosc <= (hph < 3'h2);
        end
        if (lrc_en) begin
            lph <= (lph == 3'h5) ? 3'h0 : lph + 3'h1;
            losc <= (lph < 3'h3);
        end
    end

    omc_mode_ctrl DUT (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .hosc_clk_in(hosc), .losc_clk_in(losc), .wake_in(wake), .wdt_enable_in(wdt_en),
        .high_clk_option_in(hopt), .int_high_rc_en_out(hrc_en), .rtc_xtal_en_out(xtal_en),
        .ext_osc_en_out(ext_en), .int_low_rc_en_out(lrc_en), .sys_clk_sel_out(clk_sel),
        .cpu_tick_out(cpu_tick), .wdt_tick_out(wdt_tick), .cpu_run_out(cpu_run)
    );

    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Single bit form
    task check1(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask : check1

    // One APB transfer; holds everything until pready is seen or 20 cycles pass
    task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
             input logic [3:0] st);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        pstrb <= st;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check1(pready, 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Register write, lane 0 only
    task wr(input logic [31:0] d);
        apb(1'b1, OSC_MODE_ADDR, d, 4'h1);
    endtask : wr

    // Register read and compare
    task rdchk(input logic [31:0] exp);
        apb(1'b0, OSC_MODE_ADDR, 32'h0, 4'h0);
        check(rd_v, exp);
    endtask : rdchk

    // Wait for execution, bounded
    task wait_run(input int t0, input int lim, output int n);
        while (cpu_run !== 1'b1 && cyc - t0 < lim) @(posedge sys_clk_in);
        n = cyc - t0;
        if (cpu_run !== 1'b1) bad_count++;
    endtask : wait_run

    // Raise wake and time the return to execution
    task wake_up(output int n);
        int t0;
        @(posedge sys_clk_in);
        wake <= 1'b1;
        t0 = cyc;
        wait_run(t0, 20000, n);
        @(posedge sys_clk_in);
        wake <= 1'b0;
    endtask : wake_up

    // Count pulses over a window
    task count_ticks(input int len, output int ct, output int wt);
        ct = 0;
        wt = 0;
        repeat (len) begin
            @(posedge sys_clk_in);
            ct += int'(cpu_tick === 1'b1);
            wt += int'(wdt_tick === 1'b1);
        end
    endtask : count_ticks

    // Reset with given straps, then time the start-up sequence
    task boot(input logic [2:0] opt, input logic wdt);
        int t0;
        int n;
        int exp;
        exp = int'(CFG_LOSC_CYCLES) * LP + int'(RESET_WARM_CYCLES) * HP;
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        hopt <= opt;
        wdt_en <= wdt;
        repeat (5) @(posedge sys_clk_in);
        check1(lrc_en, 1'b1);
        check1(cpu_run, 1'b0);
        rstn_in <= 1'b1;
        t0 = cyc;
        rdchk(32'h0);
        wait_run(t0, 30000, n);
        check1(n >= exp - 12 && n <= exp + 40, 1'b1);
    endtask : boot

    // Slow and normal instruction rates
    task t_rates;
        int ct;
        int wt;
        wr(32'h04);
        repeat (20) @(posedge sys_clk_in);
        check1(clk_sel, 1'b1);
        count_ticks(40 * LP, ct, wt);
        check1(wt >= 39 && wt <= 41, 1'b1);
        check1(ct >= 9 && ct <= 11, 1'b1);
        wr(32'h00);
        repeat (20) @(posedge sys_clk_in);
        check1(clk_sel, 1'b0);
        count_ticks(20 * HP, ct, wt);
        check1(ct >= 19 && ct <= 21, 1'b1);
    endtask : t_rates

    // Stop bit, unmapped address, masked write, reserved code
    task t_regs;
        wr(32'h06);
        repeat (4) @(posedge sys_clk_in);
        check1(hrc_en, 1'b0);
        check1(lrc_en, 1'b1);
        apb(1'b0, OSC_MODE_ADDR + 12'h004, 32'h0, 4'h0);
        check1(err_v, 1'b1);
        check(rd_v, 32'h0);
        apb(1'b1, OSC_MODE_ADDR, 32'h0, 4'h0);
        rdchk(32'h06);
        wr(32'hffffffff);
        rdchk(32'h06);
    endtask : t_regs

    // Idle from slow mode returns to slow mode
    task t_idle;
        int n;
        wr(32'h16);
        repeat (4) @(posedge sys_clk_in);
        check1(cpu_run, 1'b0);
        check1(lrc_en, 1'b1);
        wake_up(n);
        check1(n <= 20, 1'b1);
        rdchk(32'h06);
        check1(clk_sel, 1'b1);
    endtask : t_idle

    // Sleep from slow mode with stop set; wake into normal mode
    task t_sleep(input int exp);
        int n;
        wr(32'h0e);
        repeat (4) @(posedge sys_clk_in);
        check1(cpu_run, 1'b0);
        check1(lrc_en, 1'b0);
        check1(hrc_en | ext_en, 1'b0);
        wake_up(n);
        check1(n >= exp - 10 && n <= exp + 40, 1'b1);
        rdchk(32'h0);
        check1(clk_sel, 1'b0);
    endtask : t_sleep

    // Crystal option without watchdog: low RC stops in idle
    task t_xtal;
        int n;
        check1(ext_en, 1'b1);
        check1(hrc_en, 1'b0);
        wr(32'h10);
        repeat (4) @(posedge sys_clk_in);
        check1(lrc_en, 1'b0);
        wake_up(n);
        check1(n <= 20, 1'b1);
        repeat (4) @(posedge sys_clk_in);
        check1(lrc_en, 1'b1);
        t_sleep(int'(WAKE_XTAL_CYCLES) * HP);
        wr(32'h02);
        repeat (4) @(posedge sys_clk_in);
        check1(ext_en, 1'b0);
    endtask : t_xtal

    // RC plus crystal option with watchdog on
    task t_rtc;
        int n;
        check1(hrc_en & xtal_en, 1'b1);
        wr(32'h12);
        repeat (4) @(posedge sys_clk_in);
        check1(lrc_en, 1'b1);
        check1(hrc_en | xtal_en, 1'b0);
        wake_up(n);
        check1(n <= 20, 1'b1);
        rdchk(32'h02);
    endtask : t_rtc

    // Verdict and end of run
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // Main sequence, three boots to cover three of the six strap options
    initial begin
        boot(OPT_FAST_RC, 1'b0);
        t_rates();
        t_regs();
        t_idle();
        t_sleep(int'(WAKE_RC_CYCLES) * HP);
        boot(OPT_XTAL_32K, 1'b0);
        t_xtal();
        boot(OPT_RC_XTAL, 1'b1);
        t_rtc();
        conclude();
    end

    // Hang guard, sized above the expected run of about 80k cycles
    initial begin
        #2_000_000;
        bad_count++;
        conclude();
    end
endmodule : test_oscillator_mode_control
`default_nettype wire
